// ===== rtl/trlt_channel.sv
// one down-counting channel with auto reload and wrap pulse
// assumes count_tick is a one-cycle pulse in the clk_sys domain
`timescale 1ns/1ps
`include "trlt_map.svh"
module trlt_channel
  import trlt_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        count_tick,
  input  wire logic        cnt_wr,
  input  wire logic        rld_wr,
  input  wire logic [31:0] wr_data,
  output logic [31:0]      cnt_reg,
  output logic [31:0]      rld_reg,
  output logic             wrap_pulse
);
  logic [31:0] cnt_next;
  wire         at_zero = (cnt_reg == `TRLT_CNT_ZERO);

  assign wrap_pulse = count_tick & at_zero;
  assign cnt_next   = cnt_wr ? wr_data :
                      wrap_pulse ? rld_reg :
                      count_tick ? cnt_reg - 32'h00000001 : cnt_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_reg <= `TRLT_CNT_RST;
      rld_reg <= `TRLT_RLD_RST;
    end else begin
      cnt_reg <= cnt_next;
      if (rld_wr) rld_reg <= wr_data;
    end
  end

  wrap_reload_a: assert property (@(posedge clk_sys) disable iff (rst)
    (count_tick && at_zero && !cnt_wr) |=> (cnt_reg == $past(rld_reg)))
    else $error("reload not taken at wrap");
  count_step_a: assert property (@(posedge clk_sys) disable iff (rst)
    (count_tick && !at_zero && !cnt_wr) |=> (cnt_reg == $past(cnt_reg) - 32'h00000001))
    else $error("counter did not step down");
  count_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!count_tick && !cnt_wr) |=> $stable(cnt_reg))
    else $error("counter moved without tick");
endmodule : trlt_channel

// ===== rtl/trlt_map.svh
// register offsets, field positions, reset values and codes for the reload timer
// assumes inclusion by the timer package and modules
`ifndef TRLT_MAP_SVH
`define TRLT_MAP_SVH
`define TRLT_A_RUN      8'h00
`define TRLT_A_PIN      8'h04
`define TRLT_A_EXC      8'h08
`define TRLT_A_CTL0     8'h10
`define TRLT_A_RLD0     8'h14
`define TRLT_A_CNT0     8'h18
`define TRLT_A_CAP2     8'h2c
`define TRLT_A_STEP     8'h10
`define TRLT_CNT_RST    32'hffffffff
`define TRLT_RLD_RST    32'hffffffff
`define TRLT_CNT_ZERO   32'h00000000
`define TRLT_F_CKS_LO   0
`define TRLT_F_CKS_HI   2
`define TRLT_F_EDGE_LO  3
`define TRLT_F_EDGE_HI  4
`define TRLT_F_WIE      5
`define TRLT_F_CPE_LO   6
`define TRLT_F_CPE_HI   7
`define TRLT_F_WFLAG    8
`define TRLT_F_CFLAG    9
`define TRLT_CTL_WMASK  10'h0ff
`define TRLT_DIV_W      8
`define TRLT_DIV4_BIT   1
`define TRLT_DIV16_BIT  3
`define TRLT_DIV64_BIT  5
`define TRLT_DIV256_BIT 7
`define TRLT_CPE_OFF    2'h0
`define TRLT_CPE_RSV    2'h1
`define TRLT_CPE_IRQ    2'h3
`define TRLT_EXC_NONE   12'h000
`define TRLT_EXC_W0     12'h400
`define TRLT_EXC_W1     12'h420
`define TRLT_EXC_W2     12'h440
`define TRLT_EXC_CAP2   12'h460
`endif

// ===== rtl/trlt_pkg.sv
// types shared by the reload timer modules
// assumes trlt_map.svh for the numeric constants
package trlt_pkg;
  typedef enum logic [2:0] {
    TRLT_CK_DIV4, TRLT_CK_DIV16, TRLT_CK_DIV64, TRLT_CK_DIV256,
    TRLT_CK_RTC, TRLT_CK_PIN, TRLT_CK_RSV6, TRLT_CK_RSV7
  } trlt_cksel_t;
  typedef enum logic [1:0] {
    TRLT_EDGE_RISE, TRLT_EDGE_FALL, TRLT_EDGE_BOTH, TRLT_EDGE_BOTH2
  } trlt_edge_t;
endpackage : trlt_pkg

// ===== rtl/trlt_timer.sv
// three channel reload timer with channel 2 input capture
// assumes synchronous inputs on clk_sys and a one-cycle rtc_tick_clock pulse
`timescale 1ns/1ps
`include "trlt_map.svh"
module trlt_timer
  import trlt_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        ext_count_pin,
  input  wire logic        rtc_tick_clock,
  input  wire logic        standby,
  output logic             pin_drive_enable,
  output logic             wrap_irq_ch0,
  output logic             wrap_irq_ch1,
  output logic             wrap_irq_ch2,
  output logic             capture_irq_ch2,
  output logic             irq_any,
  output logic [11:0]      exception_code_reg
);
  logic [2:0]          channel_run_bits_reg;
  logic [9:0]          ctl_reg [3];
  logic [31:0]         cnt_q [3];
  logic [31:0]         rld_q [3];
  logic [2:0]          wrap_ev;
  logic [2:0]          tick;
  logic [31:0]         capture_value_reg;
  logic [`TRLT_DIV_W-1:0] div_reg;
  logic [`TRLT_DIV_W-1:0] div_next;
  logic                pin_reg;
  logic                pin_drive_reg;
  logic [31:0]         rdata_next;
  logic [3:0]          irq_next;
  logic [11:0]         exc_next;
  logic [2:0]          wrap_irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and pin edges
  assign div_next = div_reg + `TRLT_DIV_W'(1);
  wire pin_rise = ext_count_pin & ~pin_reg;
  wire pin_fall = ~ext_count_pin & pin_reg;
  wire [3:0] div_tick;
  assign div_tick[0] = div_next[`TRLT_DIV4_BIT] & ~div_reg[`TRLT_DIV4_BIT];
  assign div_tick[1] = div_next[`TRLT_DIV16_BIT] & ~div_reg[`TRLT_DIV16_BIT];
  assign div_tick[2] = div_next[`TRLT_DIV64_BIT] & ~div_reg[`TRLT_DIV64_BIT];
  assign div_tick[3] = div_next[`TRLT_DIV256_BIT] & ~div_reg[`TRLT_DIV256_BIT];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_reg <= '0;
      pin_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      pin_reg <= ext_count_pin;
    end
  end

  div4_period_a: assert property (@(posedge clk_sys) disable iff (rst)
    div_tick[0] |=> (!div_tick[0] [*3] ##1 div_tick[0]))
    else $error("divide by 4 tick period wrong");
  div16_period_a: assert property (@(posedge clk_sys) disable iff (rst)
    div_tick[1] |=> (!div_tick[1] [*8] ##1 !div_tick[1] [*7] ##1 div_tick[1]))
    else $error("divide by 16 tick period wrong");

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  wire sel_run = (reg_addr == `TRLT_A_RUN);
  wire sel_pin = (reg_addr == `TRLT_A_PIN);
  wire sel_exc = (reg_addr == `TRLT_A_EXC);
  wire sel_cap = (reg_addr == `TRLT_A_CAP2);
  wire [2:0] sel_ctl;
  wire [2:0] sel_rld;
  wire [2:0] sel_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // channels
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ch
      wire trlt_cksel_t cks  = trlt_cksel_t'(ctl_reg[g][`TRLT_F_CKS_HI:`TRLT_F_CKS_LO]);
      wire trlt_edge_t  edg  = trlt_edge_t'(ctl_reg[g][`TRLT_F_EDGE_HI:`TRLT_F_EDGE_LO]);
      wire              pin_ev = edg[1] ? (pin_rise | pin_fall) :
                                 (edg == TRLT_EDGE_FALL) ? pin_fall : pin_rise;
      wire              src_ev = (cks == TRLT_CK_RTC) ? rtc_tick_clock :
                                 (cks == TRLT_CK_PIN) ? pin_ev :
                                 cks[2] ? 1'b0 : div_tick[cks[1:0]];
      assign tick[g]    = channel_run_bits_reg[g] & src_ev;
      assign sel_ctl[g] = (reg_addr == `TRLT_A_CTL0 + 8'(g * `TRLT_A_STEP));
      assign sel_rld[g] = (reg_addr == `TRLT_A_RLD0 + 8'(g * `TRLT_A_STEP));
      assign sel_cnt[g] = (reg_addr == `TRLT_A_CNT0 + 8'(g * `TRLT_A_STEP));
      wire clr_wflag = reg_wr & sel_ctl[g] & ~reg_wdata[`TRLT_F_WFLAG];
      wire clr_cflag = reg_wr & sel_ctl[g] & ~reg_wdata[`TRLT_F_CFLAG];
      logic [9:0] ctl_next;
      wire [1:0] cpe_wr = reg_wdata[`TRLT_F_CPE_HI:`TRLT_F_CPE_LO];
      wire [7:0] cfg_wr = {(g == 2 && cpe_wr != `TRLT_CPE_RSV) ? cpe_wr :
                           ctl_reg[g][`TRLT_F_CPE_HI:`TRLT_F_CPE_LO],
                           reg_wdata[`TRLT_F_WIE:`TRLT_F_CKS_LO]};
      wire cap_on  = (g == 2) && ctl_reg[g][`TRLT_F_CPE_HI] && !standby;
      wire cap_ev  = cap_on & pin_ev;
      always_comb begin
        ctl_next = ctl_reg[g];
        if (reg_wr && sel_ctl[g]) ctl_next[`TRLT_F_CPE_HI:`TRLT_F_CKS_LO] = cfg_wr & 8'(`TRLT_CTL_WMASK);
        ctl_next[`TRLT_F_WFLAG] = wrap_ev[g] | (ctl_reg[g][`TRLT_F_WFLAG] & ~clr_wflag);
        ctl_next[`TRLT_F_CFLAG] = cap_ev | (ctl_reg[g][`TRLT_F_CFLAG] & ~clr_cflag);
      end
      always_ff @(posedge clk_sys) begin
        if (rst) ctl_reg[g] <= '0;
        else     ctl_reg[g] <= ctl_next;
      end
      trlt_channel u_ch (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .count_tick (tick[g]),
        .cnt_wr     (reg_wr & sel_cnt[g]),
        .rld_wr     (reg_wr & sel_rld[g]),
        .wr_data    (reg_wdata),
        .cnt_reg    (cnt_q[g]),
        .rld_reg    (rld_q[g]),
        .wrap_pulse (wrap_ev[g])
      );
      assign irq_next[g] = ctl_next[`TRLT_F_WFLAG] & ctl_next[`TRLT_F_WIE];
      rtc_src_a: assert property (@(posedge clk_sys) disable iff (rst)
        (channel_run_bits_reg[g] && cks == TRLT_CK_RTC) |-> (tick[g] == rtc_tick_clock))
        else $error("rtc tick not followed");
      pin_src_a: assert property (@(posedge clk_sys) disable iff (rst)
        (channel_run_bits_reg[g] && cks == TRLT_CK_PIN) |->
          (tick[g] == (edg[1] ? (ext_count_pin != pin_reg) :
                       edg[0] ? (pin_reg && !ext_count_pin) : (ext_count_pin && !pin_reg))))
        else $error("pin edge count wrong");
      rsv_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
        (cks == TRLT_CK_RSV6 || cks == TRLT_CK_RSV7) |-> !tick[g])
        else $error("reserved clock select counted");
      stop_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
        !channel_run_bits_reg[g] |-> !tick[g])
        else $error("stopped channel ticked");
      irq_level_a: assert property (@(posedge clk_sys) disable iff (rst)
        wrap_irq_q[g] == (ctl_reg[g][`TRLT_F_WFLAG] && ctl_reg[g][`TRLT_F_WIE]))
        else $error("wrap request level wrong");
      cap_only_ch2_a: assert property (@(posedge clk_sys) disable iff (rst)
        (g != 2) |-> (ctl_reg[g][`TRLT_F_CPE_HI:`TRLT_F_CPE_LO] == `TRLT_CPE_OFF && !ctl_reg[g][`TRLT_F_CFLAG]))
        else $error("capture state on channel without capture");
    end
  endgenerate

  wire cap2_ev = g_ch[2].cap_ev;

  always_ff @(posedge clk_sys) begin
    if (rst) capture_value_reg <= '0;
    else if (cap2_ev) capture_value_reg <= cnt_q[2];
  end

  ////////////////////////////////////////////////////////////////////////////
  // run, pin drive and read path
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      channel_run_bits_reg <= '0;
      pin_drive_reg        <= 1'b0;
    end else begin
      if (reg_wr && sel_run) channel_run_bits_reg <= reg_wdata[2:0];
      if (reg_wr && sel_pin) pin_drive_reg <= reg_wdata[0];
    end
  end

  // reads sample the registers before this edge's step
  assign rdata_next = sel_run ? {29'h0, channel_run_bits_reg} :
                      sel_pin ? {31'h0, pin_drive_reg} :
                      sel_exc ? {20'h0, exception_code_reg} :
                      sel_cap ? capture_value_reg :
                      sel_ctl[0] ? {22'h0, ctl_reg[0]} :
                      sel_ctl[1] ? {22'h0, ctl_reg[1]} :
                      sel_ctl[2] ? {22'h0, ctl_reg[2]} :
                      sel_rld[0] ? rld_q[0] : sel_rld[1] ? rld_q[1] : sel_rld[2] ? rld_q[2] :
                      sel_cnt[0] ? cnt_q[0] : sel_cnt[1] ? cnt_q[1] : sel_cnt[2] ? cnt_q[2] :
                      32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt requests and exception code
  assign wrap_irq_q  = {wrap_irq_ch2, wrap_irq_ch1, wrap_irq_ch0};
  assign irq_next[3] = g_ch[2].ctl_next[`TRLT_F_CFLAG] &
                       (g_ch[2].ctl_next[`TRLT_F_CPE_HI:`TRLT_F_CPE_LO] == `TRLT_CPE_IRQ);
  assign exc_next    = irq_next[0] ? `TRLT_EXC_W0 : irq_next[1] ? `TRLT_EXC_W1 :
                       irq_next[2] ? `TRLT_EXC_W2 : irq_next[3] ? `TRLT_EXC_CAP2 : `TRLT_EXC_NONE;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata          <= '0;
      wrap_irq_ch0       <= 1'b0;
      wrap_irq_ch1       <= 1'b0;
      wrap_irq_ch2       <= 1'b0;
      capture_irq_ch2    <= 1'b0;
      irq_any            <= 1'b0;
      exception_code_reg <= `TRLT_EXC_NONE;
      pin_drive_enable   <= 1'b0;
    end else begin
      reg_rdata          <= reg_rd ? rdata_next : 32'h00000000;
      wrap_irq_ch0       <= irq_next[0];
      wrap_irq_ch1       <= irq_next[1];
      wrap_irq_ch2       <= irq_next[2];
      capture_irq_ch2    <= irq_next[3];
      irq_any            <= |irq_next;
      exception_code_reg <= exc_next;
      pin_drive_enable   <= (reg_wr && sel_pin) ? reg_wdata[0] : pin_drive_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  wrap_flag_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    wrap_ev[0] |=> ctl_reg[0][`TRLT_F_WFLAG])
    else $error("wrap flag not set");
  wrap_irq_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wrap_ev[1] && ctl_reg[1][`TRLT_F_WIE] && !(reg_wr && sel_ctl[1])) |=> wrap_irq_ch1)
    else $error("wrap request missing");
  irq_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    wrap_irq_ch0 |-> (ctl_reg[0][`TRLT_F_WFLAG] && ctl_reg[0][`TRLT_F_WIE]))
    else $error("request without flag and enable");
  flag_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && sel_ctl[0] && !reg_wdata[`TRLT_F_WFLAG] && !wrap_ev[0]) |=> !ctl_reg[0][`TRLT_F_WFLAG])
    else $error("flag not cleared by zero");
  capture_copy_a: assert property (@(posedge clk_sys) disable iff (rst)
    cap2_ev |=> (capture_value_reg == $past(cnt_q[2])))
    else $error("capture value wrong");
  standby_cap_a: assert property (@(posedge clk_sys) disable iff (rst)
    standby |=> $stable(capture_value_reg))
    else $error("capture in standby");
  prio_code_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wrap_irq_ch0) |-> (exception_code_reg == `TRLT_EXC_W0))
    else $error("priority code wrong");
  run_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!channel_run_bits_reg[2] && !(reg_wr && sel_cnt[2])) |=> $stable(cnt_q[2]))
    else $error("stopped channel moved");
  read_before_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && sel_cnt[0]) |=> (reg_rdata == $past(cnt_q[0])))
    else $error("read not pre-step value");
  rdata_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
    !reg_rd |=> (reg_rdata == 32'h00000000))
    else $error("read data outside read cycle");
  run_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && sel_run) |=> (channel_run_bits_reg == $past(reg_wdata[2:0])))
    else $error("run bits not written");
  prio_w1_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wrap_irq_ch1 && !wrap_irq_ch0) |-> (exception_code_reg == `TRLT_EXC_W1))
    else $error("channel 1 code wrong");
  prio_w2_a: assert property (@(posedge clk_sys) disable iff (rst)
    (wrap_irq_ch2 && !wrap_irq_ch0 && !wrap_irq_ch1) |-> (exception_code_reg == `TRLT_EXC_W2))
    else $error("channel 2 code wrong");
  prio_cap_a: assert property (@(posedge clk_sys) disable iff (rst)
    (capture_irq_ch2 && wrap_irq_q == 3'h0) |-> (exception_code_reg == `TRLT_EXC_CAP2))
    else $error("capture code wrong");
  no_source_a: assert property (@(posedge clk_sys) disable iff (rst)
    !irq_any |-> (exception_code_reg == `TRLT_EXC_NONE))
    else $error("code without request");
  any_or_a: assert property (@(posedge clk_sys) disable iff (rst)
    irq_any == ((wrap_irq_q != 3'h0) || capture_irq_ch2))
    else $error("combined request wrong");
  cap_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    capture_irq_ch2 |-> (ctl_reg[2][`TRLT_F_CFLAG] && ctl_reg[2][`TRLT_F_CPE_HI:`TRLT_F_CPE_LO] == `TRLT_CPE_IRQ))
    else $error("capture request without flag and enable");
  cpe_rsv_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && sel_ctl[2] && reg_wdata[`TRLT_F_CPE_HI:`TRLT_F_CPE_LO] == `TRLT_CPE_RSV) |=>
      $stable(ctl_reg[2][`TRLT_F_CPE_HI:`TRLT_F_CPE_LO]))
    else $error("reserved capture code taken");
  cap_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && sel_ctl[2] && !reg_wdata[`TRLT_F_CFLAG] && !cap2_ev) |=> !ctl_reg[2][`TRLT_F_CFLAG])
    else $error("capture flag not cleared by zero");
  cap_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    cap2_ev |=> ctl_reg[2][`TRLT_F_CFLAG])
    else $error("capture flag not set");
  cap_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    !ctl_reg[2][`TRLT_F_CPE_HI] |-> !cap2_ev)
    else $error("capture while disabled");
  cap_edge_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ctl_reg[2][`TRLT_F_CPE_HI] && !standby && ext_count_pin && !pin_reg &&
     trlt_edge_t'(ctl_reg[2][`TRLT_F_EDGE_HI:`TRLT_F_EDGE_LO]) == TRLT_EDGE_RISE) |-> cap2_ev)
    else $error("capture edge missed");
endmodule : trlt_timer

// ===== testbench/tb_trlt_timer.sv
// self-checking bench for the three channel reload timer
// assumes trlt_pulse_src drives pin and rtc tick, clk_sys at 10 MHz
`timescale 1ns/1ps
`include "trlt_map.svh"
module tb_trlt_timer
  import trlt_pkg::*;
;
  logic        clk_sys, rst, reg_wr, reg_rd, standby, flip_req, tick_req;
  logic        pin, rtc, pde, irq0, irq1, irq2, irqc, irq_any;
  logic [7:0]  reg_addr;
  logic [11:0] exc;
  logic [31:0] reg_wdata, reg_rdata, rv, rl, cv;
  logic [31:0] last [3];
  logic [2:0]  irqv;
  int          error_cnt, n_checks, cyc, seed, d, t;
  assign irqv = {irq2, irq1, irq0};
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  trlt_timer trlt_timer_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_count_pin(pin), .rtc_tick_clock(rtc),
    .standby(standby), .pin_drive_enable(pde), .wrap_irq_ch0(irq0), .wrap_irq_ch1(irq1),
    .wrap_irq_ch2(irq2), .capture_irq_ch2(irqc), .irq_any(irq_any), .exception_code_reg(exc));
  trlt_pulse_src trlt_pulse_src_inst (.clk_sys(clk_sys), .rst(rst), .flip_req(flip_req),
    .tick_req(tick_req), .pin_out(pin), .rtc_tick(rtc));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] ca(input int ch, input int off);
    return 8'(`TRLT_A_CTL0 + ch * `TRLT_A_STEP + off);
  endfunction : ca
  function automatic logic [11:0] exp_code(input int ch);
    case (ch)
      0: return `TRLT_EXC_W0;
      1: return `TRLT_EXC_W1;
      2: return `TRLT_EXC_W2;
      3: return `TRLT_EXC_NONE;
      default: return `TRLT_EXC_CAP2;
    endcase
  endfunction : exp_code
  function automatic logic [31:0] exp_steps(input logic [1:0] e);
    return e[1] ? 32'h4 : 32'h2;
  endfunction : exp_steps
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd
  task automatic tick();
    tick_req <= 1'b1;
    @(posedge clk_sys);
    tick_req <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : tick
  task automatic flip();
    flip_req <= 1'b1;
    @(posedge clk_sys);
    flip_req <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask : flip
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reg_wr, reg_rd, standby, flip_req, tick_req, reg_addr, reg_wdata} = '0;
    rst = 1'b1;
    seed = 87064;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(ca(0, 8)); chk(rv, `TRLT_CNT_RST);
    rd(ca(0, 4)); chk(rv, `TRLT_RLD_RST);
    rd(`TRLT_A_CAP2); chk(rv, 32'h0);
    rd(8'h3c); chk(rv, 32'h0);
    $display("test reset done");
    for (int ch = 2; ch >= 0; ch--) begin
      rl = 32'h3 + (32'($random(seed)) & 32'h7);
      wr(`TRLT_A_RUN, 32'h0);
      wr(ca(ch, 0), 32'(TRLT_CK_RTC) | (32'h1 << `TRLT_F_WIE));
      wr(ca(ch, 4), rl);
      wr(ca(ch, 8), 32'h1);
      wr(`TRLT_A_RUN, 32'h1 << ch);
      tick(); rd(ca(ch, 8)); chk(rv, 32'h0);
      tick_req <= 1'b1;
      @(posedge clk_sys);
      tick_req <= 1'b0;
      rd(ca(ch, 8)); chk(rv, 32'h0);
      rd(ca(ch, 8)); chk(rv, rl);
      rd(ca(ch, 0)); chk(32'(rv[`TRLT_F_WFLAG]), 32'h1);
      chk(32'(irqv), (32'h7 << ch) & 32'h7);
      chk(32'(exc), 32'(exp_code(ch)));
      for (int k = ch + 1; k < 3; k++) begin
        rd(ca(k, 8)); chk(rv, last[k]);
      end
      repeat (rl) tick();
      rd(ca(ch, 8)); chk(rv, 32'h0);
      tick(); rd(ca(ch, 8)); chk(rv, rl);
      last[ch] = rl;
    end
    chk(32'(irq_any), 32'h1);
    wr(`TRLT_A_RUN, 32'h0);
    for (int ch = 0; ch < 3; ch++) begin
      wr(ca(ch, 0), 32'(TRLT_CK_RTC) | (32'h1 << `TRLT_F_WFLAG));
      rd(ca(ch, 0)); chk(32'(rv[`TRLT_F_WFLAG]), 32'h1);
      chk(32'(irqv[ch]), 32'h0);
      chk(32'(exc), 32'(exp_code(ch + 1)));
      wr(ca(ch, 0), 32'(TRLT_CK_RTC)); rd(ca(ch, 0)); chk(32'(rv[`TRLT_F_WFLAG]), 32'h0);
    end
    chk(32'({irq_any, exc}), 32'h0);
    $display("test wrap done");
    for (int c = 0; c < 8; c++) begin
      if (c != 4 && c != 5) begin
        d = (c < 4) ? (1024 >> (2 * c + 2)) : 0;
        t = (c < 4) ? 1 : 0;
        wr(ca(1, 0), 32'(c)); wr(ca(1, 8), 32'h1000); wr(`TRLT_A_RUN, 32'h2);
        repeat (1024) @(posedge clk_sys);
        wr(`TRLT_A_RUN, 32'h0); rd(ca(1, 8));
        chk(32'(rv inside {[32'h1000 - d - t : 32'h1000 - d + t]}), 32'h1);
      end
    end
    $display("test divider done");
    wr(`TRLT_A_PIN, 32'h1); @(posedge clk_sys); #1 chk(32'(pde), 32'h1);
    wr(`TRLT_A_PIN, 32'h0); @(posedge clk_sys); #1 chk(32'(pde), 32'h0);
    for (int e = 0; e < 4; e++) begin
      wr(ca(1, 0), 32'(TRLT_CK_PIN) | 32'(e << `TRLT_F_EDGE_LO));
      wr(ca(1, 8), 32'h64); wr(`TRLT_A_RUN, 32'h2);
      repeat (4) flip();
      wr(`TRLT_A_RUN, 32'h0); rd(ca(1, 8)); chk(rv, 32'h64 - exp_steps(2'(e)));
    end
    $display("test pin done");
    cv = $random(seed);
    wr(ca(2, 0), 32'(TRLT_CK_RTC) | 32'hc0);
    wr(ca(2, 8), cv);
    flip(); rd(`TRLT_A_CAP2); chk(rv, cv);
    chk(32'({irqc, exc}), 32'(`TRLT_EXC_CAP2) | 32'h1000);
    flip(); wr(ca(2, 8), ~cv);
    standby <= 1'b1;
    flip();
    standby <= 1'b0;
    rd(`TRLT_A_CAP2); chk(rv, cv);
    flip();
    wr(ca(2, 0), 32'(TRLT_CK_RTC) | 32'h40 | (32'h1 << `TRLT_F_CFLAG));
    rd(ca(2, 0)); chk(32'(rv[7:6]), 32'h3);
    wr(ca(2, 0), 32'(TRLT_CK_RTC) | 32'h80);
    flip(); rd(`TRLT_A_CAP2); chk(rv, ~cv);
    rd(ca(2, 0)); chk(32'({irqc, rv[`TRLT_F_CFLAG]}), 32'h1);
    wr(`TRLT_A_CAP2, cv); rd(`TRLT_A_CAP2); chk(rv, ~cv);
    $display("test capture done");
    print_verdict();
  end
endmodule : tb_trlt_timer

// ===== testbench/trlt_pulse_src.sv
// external pin pulse source and rtc tick source for the reload timer
// assumes one-cycle requests from the bench on clk_sys
`timescale 1ns/1ps
module trlt_pulse_src (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic flip_req,
  input  wire logic tick_req,
  output logic      pin_out,
  output logic      rtc_tick
);
  logic [1:0] hold_reg;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_out  <= 1'b0;
      rtc_tick <= 1'b0;
      hold_reg <= 2'h0;
    end else begin
      rtc_tick <= tick_req;
      if (flip_req && hold_reg == 2'h0) begin
        pin_out  <= ~pin_out;
        hold_reg <= 2'h3;
      end else if (hold_reg != 2'h0) begin
        hold_reg <= hold_reg - 2'h1;
      end
    end
  end
endmodule : trlt_pulse_src
